//--- bench/nce_entry_assertions.sv
// Port checks for the noncritical exception entry block.
`timescale 1ns/100ps
`default_nettype none
module nce_entry_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire nce_pkg::nce_instr_t instr,
  input wire logic ext_int_req,
  input wire logic [31:0] machine_state_reg,
  input wire logic [31:0] save_restore_pc,
  input wire logic [31:0] save_restore_state,
  input wire logic [31:0] fault_data_address,
  input wire logic [31:0] exception_syndrome,
  input wire nce_pkg::nce_redirect_t redirect
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_entry(nce_pkg::nce_cause_t c);
    redirect.taken && redirect.cause == c;
  endsequence
  a_ext_masked: assert property (!machine_state_reg[15] && ext_int_req && !instr.valid |=> !redirect.taken)
    else $error("masked external request taken");
  a_save_state: assert property (redirect.taken |-> save_restore_state == $past(machine_state_reg))
    else $error("saved state wrong");
  a_state_clear: assert property (redirect.taken |-> (machine_state_reg & 32'h0004_C430) == 32'h0000_0000
    && (machine_state_reg & 32'h0002_1200) == ($past(machine_state_reg) & 32'h0002_1200)) else $error("entry state wrong");
  a_sysc_aux: assert property (s_entry(nce_pkg::EXC_SYSC) |-> !machine_state_reg[25] && !machine_state_reg[8])
    else $error("aux bits not cleared");
  a_return_load: assert property (redirect.restore |-> machine_state_reg == $past(save_restore_state)
    && redirect.target == $past(save_restore_pc)) else $error("return restore wrong");
  a_align_fault: assert property (instr.valid && instr.cache_read_instr && instr.eff_addr[1:0] != 2'b00
    |=> s_entry(nce_pkg::EXC_ALIGN) ##0 fault_data_address == $past(instr.eff_addr)
    && save_restore_pc == $past(instr.pc) && redirect.target[15:0] == 16'h0600) else $error("alignment entry wrong");
  a_prog_flags: assert property (s_entry(nce_pkg::EXC_PROG) |-> $onehot(exception_syndrome[27:25])
    && exception_syndrome[30:28] == 3'b000 && exception_syndrome[24:0] == 25'h000_0000) else $error("syndrome wrong");
  a_one_entry: assert property (redirect.taken |-> $onehot(redirect.cause) && !redirect.restore
    && redirect.cause != nce_pkg::EXC_NONE) else $error("entry not single");
endmodule // nce_entry_assertions
bind nce_entry nce_entry_assertions chk_u (.core_clk(core_clk), .reset_n(reset_n), .instr(instr),
  .ext_int_req(ext_int_req), .machine_state_reg(machine_state_reg), .save_restore_pc(save_restore_pc),
  .save_restore_state(save_restore_state), .fault_data_address(fault_data_address),
  .exception_syndrome(exception_syndrome), .redirect(redirect));
`default_nettype wire

//--- bench/nce_int_merge.sv
// Model of the interrupt controller that merges external sources into one level request.
`timescale 1ns/100ps
`default_nettype none
module nce_int_merge #(
  parameter int unsigned N_SRC = 4
) (
  input wire logic [N_SRC-1:0] src,
  output logic ext_int_req
);
  assign ext_int_req = |src;
endmodule // nce_int_merge
`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the noncritical exception entry block.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk, reset_n, state_wr_en, ext_int_req;
  logic [3:0] int_src;
  logic [31:0] state_wr_data, machine_state_reg, save_restore_pc, save_restore_state, fault_data_address, syn;
  logic [31:0] vec_prefix;
  nce_pkg::nce_instr_t instr, v;
  nce_pkg::nce_redirect_t redirect;
  int miscompares = 0, check_count = 0, cycles = 0;
  nce_int_merge merge_u (.src(int_src), .ext_int_req(ext_int_req));
  nce_entry dut_u (.core_clk(core_clk), .reset_n(reset_n), .instr(instr), .ext_int_req(ext_int_req),
    .vector_prefix_reg(vec_prefix), .state_wr_en(state_wr_en), .state_wr_data(state_wr_data),
    .machine_state_reg(machine_state_reg), .save_restore_pc(save_restore_pc),
    .save_restore_state(save_restore_state), .fault_data_address(fault_data_address),
    .exception_syndrome(syn), .redirect(redirect));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_redir(input logic tk, input logic rs, input nce_pkg::nce_cause_t c);
    check_count++;
    if ({redirect.taken, redirect.restore, redirect.cause} !== {tk, rs, c}) begin
      miscompares++;
      $display("ERROR %0t redirect %b want %b", $time, {redirect.taken, redirect.restore, redirect.cause}, {tk, rs, c});
    end
  endtask
  task automatic wr_ms(input logic [31:0] d);
    @(negedge core_clk) state_wr_en = 1'b1;
    state_wr_data = d;
    @(negedge core_clk) state_wr_en = 1'b0;
  endtask
  // Presents v for one cycle; outputs are settled at the negedge that ends it.
  task automatic go;
    @(negedge core_clk) instr = v;
    @(negedge core_clk) instr = '0;
  endtask
  task automatic t_sysc;
    wr_ms(32'hFFFF_FFFF);
    v = '0;
    v.valid = 1'b1;
    v.sys_call = 1'b1;
    v.next_pc = 32'h0000_1004;
    go;
    chk(save_restore_pc, 32'h0000_1004);
    chk(machine_state_reg, 32'hFDFB_3ACF);
    chk(redirect.target, 32'hABCD_0C00);
    chk_redir(1'b1, 1'b0, nce_pkg::EXC_SYSC);
    v.sys_call = 1'b0;
    v.return_from_int = 1'b1;
    go;
    chk(machine_state_reg, 32'hFFFF_FFFF);
    chk(redirect.target, 32'h0000_1004);
    chk_redir(1'b0, 1'b1, nce_pkg::EXC_NONE);
    $display("t_sysc done");
  endtask
  task automatic t_ext;
    wr_ms(32'h0000_0000);
    int_src = 4'h4;
    repeat (3) @(negedge core_clk);
    chk(save_restore_pc, 32'h0000_1004);
    chk_redir(1'b0, 1'b0, nce_pkg::EXC_NONE);
    v = '0;
    v.valid = 1'b1;
    v.next_pc = 32'h0000_2008;
    @(negedge core_clk) instr = v;
    wr_ms(32'h0000_C230);
    @(negedge core_clk) instr = '0;
    int_src = 4'h0;
    chk(save_restore_pc, 32'h0000_2008);
    chk(save_restore_state, 32'h0000_C230);
    chk(machine_state_reg, 32'h0000_0200);
    chk(redirect.target, 32'hABCD_0500);
    chk_redir(1'b1, 1'b0, nce_pkg::EXC_EXT);
    $display("t_ext done");
  endtask
  task automatic t_align;
    vec_prefix = 32'h1357_FFFF;
    v = '0;
    v.valid = 1'b1;
    v.sys_call = 1'b1;
    v.cache_read_instr = 1'b1;
    v.pc = 32'h0000_3000;
    v.eff_addr = 32'h0000_3002;
    go;
    chk(save_restore_pc, 32'h0000_3000);
    chk(fault_data_address, 32'h0000_3002);
    chk(redirect.target, 32'h1357_0600);
    chk_redir(1'b1, 1'b0, nce_pkg::EXC_ALIGN);
    v = '0;
    v.valid = 1'b1;
    v.cache_block_zero = 1'b1;
    v.storage_inhibit_or_wt = 1'b1;
    v.pc = 32'h0000_4000;
    v.eff_addr = 32'h0000_4000;
    go;
    chk(save_restore_pc, 32'h0000_4000);
    chk(save_restore_state, 32'h0000_0200);
    v = '0;
    v.valid = 1'b1;
    v.load_reserve_word = 1'b1;
    v.pc = 32'h0000_4100;
    v.eff_addr = 32'h0000_4101;
    go;
    chk(save_restore_pc, 32'h0000_4100);
    chk(fault_data_address, 32'h0000_4101);
    v = '0;
    v.valid = 1'b1;
    v.store_cond_word = 1'b1;
    v.cache_block_zero = 1'b1;
    v.pc = 32'h0000_4200;
    v.eff_addr = 32'h0000_4204;
    go;
    chk_redir(1'b0, 1'b0, nce_pkg::EXC_NONE);
    chk(save_restore_pc, 32'h0000_4100);
    chk(fault_data_address, 32'h0000_4101);
    $display("t_align done");
  endtask
  task automatic t_prog;
    for (int k = 0; k < 4; k++) begin
      wr_ms(32'h0000_4000);
      v = '0;
      v.valid = 1'b1;
      v.pc = 32'h0000_5000;
      v.illegal_opcode = (k == 0);
      v.privileged = (k == 1);
      v.trap_taken = (k == 2);
      v.mem_mgmt = (k == 3);
      go;
      chk(syn, 32'h0800_0000 >> (k % 3));
      chk(save_restore_pc, 32'h0000_5000);
      chk(save_restore_state, 32'h0000_4000);
      chk(redirect.target, 32'h1357_0700);
      chk_redir(1'b1, 1'b0, nce_pkg::EXC_PROG);
    end
    wr_ms(32'h0000_0010);
    v = '0;
    v.valid = 1'b1;
    v.pc = 32'h0000_6000;
    v.privileged = 1'b1;
    v.mem_mgmt = 1'b1;
    go;
    chk_redir(1'b0, 1'b0, nce_pkg::EXC_NONE);
    chk(save_restore_pc, 32'h0000_5000);
    $display("t_prog done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      close_out;
    end
  end
  initial begin
    instr = '0;
    v = '0;
    int_src = 4'h0;
    state_wr_en = 1'b0;
    state_wr_data = 32'h0000_0000;
    vec_prefix = 32'hABCD_0000;
    reset_n = 1'b0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    t_sysc;
    t_ext;
    t_align;
    t_prog;
    close_out;
  end
endmodule // tb
`default_nettype wire

//--- rtl/nce_entry.sv
// Noncritical exception entry and return logic of the core.
`timescale 1ns/100ps
`default_nettype none

module nce_entry (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire nce_pkg::nce_instr_t instr,
  input wire logic ext_int_req,
  input wire logic [31:0] vector_prefix_reg,
  input wire logic state_wr_en,
  input wire logic [31:0] state_wr_data,
  output logic [31:0] machine_state_reg,
  output logic [31:0] save_restore_pc,
  output logic [31:0] save_restore_state,
  output logic [31:0] fault_data_address,
  output logic [31:0] exception_syndrome,
  output nce_pkg::nce_redirect_t redirect
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  nce_pkg::nce_state_t state_reg;
  nce_pkg::nce_state_t state_next;

  logic align_fault;
  logic illegal_fault;
  logic priv_fault;
  logic trap_fault;
  logic prog_fault;
  logic ext_pending;
  logic [31:0] ms;
  logic [31:0] entry_state;

  // ----------------------------------------------------------------
  // Condition detection.
  // ----------------------------------------------------------------
  always_comb begin
    ms = state_reg.machine_state;
    align_fault = instr.valid && ((instr.cache_block_zero && instr.storage_inhibit_or_wt) ||
      ((instr.cache_read_instr || instr.load_reserve_word || instr.store_cond_word) &&
       (instr.eff_addr[1:0] != 2'b00)));
    illegal_fault = instr.valid && (instr.illegal_opcode ||
      (instr.mem_mgmt && !ms[nce_pkg::MS_INSTR_TRANSLATE_ON] &&
       !ms[nce_pkg::MS_DATA_TRANSLATE_ON]));
    priv_fault = instr.valid && instr.privileged && ms[nce_pkg::MS_USER_MODE_FLAG];
    trap_fault = instr.valid && instr.trap_taken;
    prog_fault = illegal_fault || priv_fault || trap_fault;
    // The single merged level is only honoured with the enable bit set.
    ext_pending = ext_int_req && ms[nce_pkg::MS_EXT_INT_ENABLE];
    entry_state = ms;
    entry_state[nce_pkg::MS_WAIT_STATE_EN] = 1'b0;
    entry_state[nce_pkg::MS_EXT_INT_ENABLE] = 1'b0;
    entry_state[nce_pkg::MS_USER_MODE_FLAG] = 1'b0;
    entry_state[nce_pkg::MS_DBG_WAIT_EN] = 1'b0;
    entry_state[nce_pkg::MS_INSTR_TRANSLATE_ON] = 1'b0;
    entry_state[nce_pkg::MS_DATA_TRANSLATE_ON] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.redirect.taken = 1'b0;
    state_next.redirect.restore = 1'b0;
    state_next.redirect.cause = nce_pkg::EXC_NONE;
    state_next.redirect.target = state_reg.redirect.target;
    if (state_wr_en) begin
      state_next.machine_state = state_wr_data;
    end
    // Fixed priority: instruction faults first, then system call, then the
    // external level, and return only when nothing is taken.
    if (align_fault) begin
      state_next.save_pc = instr.pc;
      state_next.save_state = ms;
      state_next.fault_addr = instr.eff_addr;
      state_next.machine_state = entry_state;
      state_next.redirect.taken = 1'b1;
      state_next.redirect.cause = nce_pkg::EXC_ALIGN;
      state_next.redirect.target = {vector_prefix_reg[31:16], nce_pkg::VEC_ALIGNMENT};
    end else if (prog_fault) begin
      state_next.save_pc = instr.pc;
      state_next.save_state = ms;
      state_next.machine_state = entry_state;
      state_next.syndrome = nce_pkg::RESET_WORD;
      state_next.syndrome[nce_pkg::SY_MCHECK_INSTR_FLAG] =
        state_reg.syndrome[nce_pkg::SY_MCHECK_INSTR_FLAG];
      if (illegal_fault) begin
        state_next.syndrome[nce_pkg::SY_ILLEGAL_OP_FLAG] = 1'b1;
      end else if (priv_fault) begin
        state_next.syndrome[nce_pkg::SY_PRIV_VIOLATION_FLAG] = 1'b1;
      end else begin
        state_next.syndrome[nce_pkg::SY_TRAP_FLAG] = 1'b1;
      end
      state_next.redirect.taken = 1'b1;
      state_next.redirect.cause = nce_pkg::EXC_PROG;
      state_next.redirect.target = {vector_prefix_reg[31:16], nce_pkg::VEC_PROGRAM};
    end else if (instr.valid && instr.sys_call) begin
      state_next.save_pc = instr.next_pc;
      state_next.save_state = ms;
      state_next.machine_state = entry_state;
      state_next.machine_state[nce_pkg::MS_AUX_PROC_AVAIL] = 1'b0;
      state_next.machine_state[nce_pkg::MS_AUX_EXC_EN] = 1'b0;
      state_next.redirect.taken = 1'b1;
      state_next.redirect.cause = nce_pkg::EXC_SYSC;
      state_next.redirect.target = {vector_prefix_reg[31:16], nce_pkg::VEC_SYS_CALL};
    end else if (ext_pending) begin
      // The external request is taken at an instruction boundary, so the
      // resume point is the next sequential address of the current slot.
      state_next.save_pc = instr.next_pc;
      state_next.save_state = ms;
      state_next.machine_state = entry_state;
      state_next.redirect.taken = 1'b1;
      state_next.redirect.cause = nce_pkg::EXC_EXT;
      state_next.redirect.target = {vector_prefix_reg[31:16], nce_pkg::VEC_EXTERNAL};
    end else if (instr.valid && instr.return_from_int) begin
      state_next.machine_state = state_reg.save_state;
      state_next.redirect.restore = 1'b1;
      state_next.redirect.target = state_reg.save_pc;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg.machine_state <= nce_pkg::RESET_WORD;
      state_reg.save_pc <= nce_pkg::RESET_WORD;
      state_reg.save_state <= nce_pkg::RESET_WORD;
      state_reg.fault_addr <= nce_pkg::RESET_WORD;
      state_reg.syndrome <= nce_pkg::RESET_WORD;
      state_reg.redirect.taken <= 1'b0;
      state_reg.redirect.restore <= 1'b0;
      state_reg.redirect.target <= nce_pkg::RESET_WORD;
      state_reg.redirect.cause <= nce_pkg::EXC_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign machine_state_reg = state_reg.machine_state;
  assign save_restore_pc = state_reg.save_pc;
  assign save_restore_state = state_reg.save_state;
  assign fault_data_address = state_reg.fault_addr;
  assign exception_syndrome = state_reg.syndrome;
  assign redirect = state_reg.redirect;

endmodule // nce_entry

`default_nettype wire

//--- rtl/nce_pkg.sv
// Package of constants and carrier types for the noncritical exception entry block.
`default_nettype none

package nce_pkg;

  // ----------------------------------------------------------------
  // Machine state bit positions (bit 0 is the least significant).
  // ----------------------------------------------------------------
  localparam int unsigned MS_AUX_PROC_AVAIL = 25;
  localparam int unsigned MS_WAIT_STATE_EN = 18;
  localparam int unsigned MS_CRITICAL_INT_EN = 17;
  localparam int unsigned MS_EXT_INT_ENABLE = 15;
  localparam int unsigned MS_USER_MODE_FLAG = 14;
  localparam int unsigned MS_MACHINE_CHECK_EN = 12;
  localparam int unsigned MS_DBG_WAIT_EN = 10;
  localparam int unsigned MS_DBG_INT_EN = 9;
  localparam int unsigned MS_AUX_EXC_EN = 8;
  localparam int unsigned MS_INSTR_TRANSLATE_ON = 5;
  localparam int unsigned MS_DATA_TRANSLATE_ON = 4;

  // ----------------------------------------------------------------
  // Syndrome bit positions.
  // ----------------------------------------------------------------
  localparam int unsigned SY_MCHECK_INSTR_FLAG = 31;
  localparam int unsigned SY_ILLEGAL_OP_FLAG = 27;
  localparam int unsigned SY_PRIV_VIOLATION_FLAG = 26;
  localparam int unsigned SY_TRAP_FLAG = 25;

  // ----------------------------------------------------------------
  // Vector offsets and reset values.
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_EXTERNAL = 16'h0500;
  localparam logic [15:0] VEC_ALIGNMENT = 16'h0600;
  localparam logic [15:0] VEC_PROGRAM = 16'h0700;
  localparam logic [15:0] VEC_SYS_CALL = 16'h0C00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    EXC_NONE = 5'b0_0001,
    EXC_ALIGN = 5'b0_0010,
    EXC_PROG = 5'b0_0100,
    EXC_SYSC = 5'b0_1000,
    EXC_EXT = 5'b1_0000
  } nce_cause_t;

  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic cache_block_zero;
    logic cache_read_instr;
    logic load_reserve_word;
    logic store_cond_word;
    logic [31:0] eff_addr;
    logic storage_inhibit_or_wt;
    logic illegal_opcode;
    logic privileged;
    logic mem_mgmt;
    logic trap_taken;
    logic sys_call;
    logic return_from_int;
  } nce_instr_t;

  typedef struct packed {
    logic taken;
    logic restore;
    logic [31:0] target;
    nce_cause_t cause;
  } nce_redirect_t;

  typedef struct packed {
    logic [31:0] machine_state;
    logic [31:0] save_pc;
    logic [31:0] save_state;
    logic [31:0] fault_addr;
    logic [31:0] syndrome;
    nce_redirect_t redirect;
  } nce_state_t;

endpackage

`default_nettype wire
